// ---- design/io_expansion_pkg.sv ----
/*
  io_expansion_pkg: constants for the I/O expansion bus port.
  Assumes a 250 MHz system clock (mclk) and an I/O space driven by a
  simple internal request port.
*/
package io_expansion_pkg;
  localparam int CLK_HZ = 250000000;
  localparam int BUS_CLK_FULL_HZ = 40000000;
  localparam int BUS_CLK_REDUCED_HZ = 20000000;
  // half period of the bus clock in mclk cycles, rounded down
  localparam int HALF_FULL = CLK_HZ / (2 * BUS_CLK_FULL_HZ);
  localparam int HALF_REDUCED = CLK_HZ / (2 * BUS_CLK_REDUCED_HZ);
  localparam int IO_ADDR_W = 16;
  localparam logic [15:0] IO_WINDOW_TOP = 16'h00FF;
  localparam int GP_PINS = 7;
  // pin index in the programmable set
  localparam int PIN_TO0 = 0;
  localparam int PIN_TO1 = 1;
  localparam int PIN_TI0 = 2;
  localparam int PIN_TI1 = 3;
  localparam int PIN_B4 = 4;
  localparam int PIN_B9 = 5;
  localparam int PIN_B14 = 6;
  localparam logic [6:0] MODE_RESET = 7'h00;
  localparam logic [6:0] DIR_RESET = 7'h7F;
  localparam logic [6:0] DATA_RESET = 7'h00;
endpackage

// ---- design/io_expansion_bus_port.sv ----
/*
  io_expansion_bus_port: host end of a parallel I/O expansion connector
  with programmable pins. Assumes one board on the bus; the core issues
  one I/O request at a time and waits for done.
*/
`timescale 1ns/10ps
// Contract
// RULE1 - address lines are outputs only; top bit absent on reduced variant
// RULE2 - data bus driven on writes only, released otherwise
// RULE3 - strobes active low, change on bus clock edges only
// RULE4 - chip select for I/O access to addresses 0 through FF
// RULE5 - board may stretch cycles with active-low async ready, synchronised
// RULE6 - ready left open means no wait states
// RULE7 - interrupt inputs 0 and 1 active high, synchronised
// RULE8 - third interrupt, full variant only, goes to channel 3
// RULE9 - open interrupt inputs read as inactive
// RULE10 - bus clock output 40 MHz full, 20 MHz reduced; divider gives about 41.67 MHz and 20.83 MHz from 250 MHz
// RULE11 - reset output in both polarities, same condition
// RULE12 - software keeps shared serial clock as output
// RULE13 - timer outputs selectable as timer or programmable bit
// RULE14 - timer inputs selectable as timer or programmable bit
// RULE15 - bits 4, 9, 14 are programmable bits
// RULE16 - board leaves reserved pins open on reduced variant
// RULE17 - only one board attached at a time
// RULE18 - mode and direction bits choose normal, pulled in, out, bare in
// RULE19 - one data bit per programmable pin
// RULE20 - never read and write together; select only with a strobe
module io_expansion_bus_port
  import io_expansion_pkg::*;
#(
  parameter bit FULL_VARIANT = 1'b1
)(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic busClock,
  input wire logic ioReq,
  input wire logic ioWrite,
  input wire logic [io_expansion_pkg::IO_ADDR_W-1:0] ioAddr,
  input wire logic [7:0] ioWdata,
  output logic ioDone,
  output logic ioHit,
  output logic [7:0] ioRdata,
  output logic busClockOut,
  output logic [7:0] addrOut,
  output logic [7:0] dataOut,
  output logic dataOe,
  input wire logic [7:0] dataIn,
  output logic csN,
  output logic rdN,
  output logic wrN,
  input wire logic asyncReadyN,
  input wire logic irqCh0,
  input wire logic irqCh1,
  input wire logic irqCh3Ext,
  output logic [3:0] irqOut,
  output logic sysReset,
  output logic sysResetN,
  input wire logic [6:0] gpMode,
  input wire logic [6:0] gpDir,
  input wire logic [6:0] gpWdata,
  output logic [6:0] gpRdata,
  input wire logic [1:0] timerOutFn,
  output logic [1:0] timerInFn,
  output logic [6:0] gpPinOut,
  output logic [6:0] gpPinOe,
  output logic [6:0] gpPull,
  input wire logic [6:0] gpPinIn
);
  import io_expansion_pkg::*;

  localparam int HALF = FULL_VARIANT ? HALF_FULL : HALF_REDUCED;

  function automatic logic agree3(input logic [2:0] s);
    agree3 = s[1] & s[2];
  endfunction

  // ==========================================================
  // bus clock divider
  logic [7:0] divCnt;
  logic [7:0] next_divCnt;
  logic busClk;
  logic next_busClk;
  logic riseTick;
  // RULE10 bus clock rate
  always_comb
  begin
    riseTick = 1'b0;
    next_busClk = busClk;
    next_divCnt = divCnt + 8'h01;
    if (divCnt == 8'(HALF - 1))
    begin
      next_divCnt = 8'h00;
      next_busClk = ~busClk;
      riseTick = ~busClk;
    end
  end
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      divCnt <= 8'h00;
      busClk <= 1'b0;
    end
    else
    begin
      divCnt <= next_divCnt;
      busClk <= next_busClk;
    end
  end
  assign busClockOut = busClk;

  // ==========================================================
  // reset outputs and input synchronisers
  logic [2:0] rstSync;
  logic [2:0] rdySync;
  logic [2:0] irqSync [3];
  // RULE11 both reset polarities
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstSync <= 3'h0;
      sysReset <= 1'b1;
      sysResetN <= 1'b0;
    end
    else
    begin
      rstSync <= {rstSync[1:0], 1'b1};
      sysReset <= ~rstSync[2];
      sysResetN <= rstSync[2];
    end
  end
  // RULE5 ready synchroniser
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdySync <= 3'h7;
      irqSync[0] <= 3'h0;
      irqSync[1] <= 3'h0;
      irqSync[2] <= 3'h0;
    end
    else
    begin
      rdySync <= {rdySync[1:0], asyncReadyN};
      irqSync[0] <= {irqSync[0][1:0], irqCh0};
      irqSync[1] <= {irqSync[1][1:0], irqCh1};
      irqSync[2] <= {irqSync[2][1:0], irqCh3Ext};
    end
  end
  // open ready pin floats high via pull-up, so readyNow stays true
  logic readyNow;
  assign readyNow = ~(~rdySync[1] & ~rdySync[2]);

  logic [3:0] next_irq;
  // RULE7 RULE8 RULE9 channel mapping, open pins low
  always_comb
  begin
    next_irq = 4'h0;
    next_irq[0] = agree3(irqSync[0]);
    next_irq[1] = agree3(irqSync[1]);
    next_irq[3] = FULL_VARIANT ? agree3(irqSync[2]) : 1'b0;
  end
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      irqOut <= 4'h0;
    else
      irqOut <= next_irq;
  end

  // ==========================================================
  // bus cycle sequencer
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_STRB = 4'b0100,
    ST_END = 4'b1000
  } bus_state_e;
  bus_state_e state;
  bus_state_e next_state;
  logic next_csN;
  logic next_rdN;
  logic next_wrN;
  logic next_dataOe;
  logic next_ioDone;
  logic next_ioHit;
  logic [7:0] next_addrOut;
  logic [7:0] next_dataOut;
  logic [7:0] next_ioRdata;
  logic inWindow;
  // RULE4 window decode
  assign inWindow = ioAddr <= IO_WINDOW_TOP;

  always_comb
  begin
    next_state = state;
    next_csN = csN;
    next_rdN = rdN;
    next_wrN = wrN;
    next_dataOe = dataOe;
    next_addrOut = addrOut;
    next_dataOut = dataOut;
    next_ioRdata = ioRdata;
    next_ioDone = 1'b0;
    next_ioHit = ioHit;
    case (state)
      ST_IDLE:
      begin
        if (ioReq && !ioDone)
        begin
          if (inWindow)
          begin
            next_state = ST_ADDR;
            next_ioHit = 1'b1;
          end
          else
          begin
            next_ioDone = 1'b1;
            next_ioHit = 1'b0;
            next_ioRdata = 8'h00;
          end
        end
      end
      ST_ADDR:
      begin
        // RULE3 strobes move only on bus clock rising edges
        if (riseTick)
        begin
          // RULE1 top address bit held low on reduced variant
          next_addrOut = {FULL_VARIANT ? ioAddr[7] : 1'b0, ioAddr[6:0]};
          // RULE2 drive data only on writes
          next_dataOe = ioWrite;
          next_dataOut = ioWdata;
          // RULE20 one strobe, select with it
          next_csN = 1'b0;
          next_rdN = ioWrite;
          next_wrN = ~ioWrite;
          next_state = ST_STRB;
        end
      end
      ST_STRB:
      begin
        // RULE5 RULE6 wait while ready held low
        if (riseTick && readyNow)
        begin
          if (!rdN)
            next_ioRdata = dataIn;
          next_csN = 1'b1;
          next_rdN = 1'b1;
          next_wrN = 1'b1;
          next_state = ST_END;
        end
      end
      ST_END:
      begin
        if (riseTick)
        begin
          next_dataOe = 1'b0;
          next_ioDone = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_IDLE;
      csN <= 1'b1;
      rdN <= 1'b1;
      wrN <= 1'b1;
      dataOe <= 1'b0;
      addrOut <= 8'h00;
      dataOut <= 8'h00;
      ioRdata <= 8'h00;
      ioDone <= 1'b0;
      ioHit <= 1'b0;
    end
    else
    begin
      state <= next_state;
      csN <= next_csN;
      rdN <= next_rdN;
      wrN <= next_wrN;
      dataOe <= next_dataOe;
      addrOut <= next_addrOut;
      dataOut <= next_dataOut;
      ioRdata <= next_ioRdata;
      ioDone <= next_ioDone;
      ioHit <= next_ioHit;
    end
  end

  // ==========================================================
  // programmable pins on the link clock
  // link side: pins sampled and driven on busClock, config crosses in
  logic [6:0] cfgMode [2];
  logic [6:0] cfgDir [2];
  logic [6:0] cfgData [2];
  logic [1:0] tofn [2];
  logic [6:0] pinS1;
  logic [6:0] pinS2;
  logic [6:0] pinS3;
  logic [6:0] next_pinOut;
  logic [6:0] next_pinOe;
  logic [6:0] next_pull;
  logic [6:0] lMode;
  logic [6:0] lDir;
  logic [6:0] lData;
  logic [6:0] normOut;
  logic [6:0] normOe;
  always_ff @(posedge busClock or negedge resetn)
  begin
    if (!resetn)
    begin
      cfgMode[0] <= MODE_RESET;
      cfgMode[1] <= MODE_RESET;
      cfgDir[0] <= DIR_RESET;
      cfgDir[1] <= DIR_RESET;
      cfgData[0] <= DATA_RESET;
      cfgData[1] <= DATA_RESET;
      tofn[0] <= 2'h0;
      tofn[1] <= 2'h0;
    end
    else
    begin
      cfgMode[0] <= gpMode;
      cfgMode[1] <= cfgMode[0];
      cfgDir[0] <= gpDir;
      cfgDir[1] <= cfgDir[0];
      cfgData[0] <= gpWdata;
      cfgData[1] <= cfgData[0];
      tofn[0] <= timerOutFn;
      tofn[1] <= tofn[0];
    end
  end
  assign lMode = cfgMode[1];
  assign lDir = cfgDir[1];
  assign lData = cfgData[1];

  always_comb
  begin
    normOut = 7'h00;
    normOe = 7'h00;
    // RULE13 normal function of timer outputs
    normOut[PIN_TO0] = tofn[1][0];
    normOut[PIN_TO1] = tofn[1][1];
    normOe[PIN_TO0] = 1'b1;
    normOe[PIN_TO1] = 1'b1;
  end

  // RULE18 mode and direction decode
  always_comb
  begin
    for (int i = 0; i < GP_PINS; i++)
    begin
      next_pinOe[i] = lMode[i] ? ~lDir[i] : (~lDir[i] & normOe[i]);
      next_pinOut[i] = lMode[i] ? lData[i] : normOut[i];
      next_pull[i] = ~lMode[i] & lDir[i];
    end
  end

  always_ff @(posedge busClock or negedge resetn)
  begin
    if (!resetn)
    begin
      gpPinOut <= 7'h00;
      gpPinOe <= 7'h00;
      gpPull <= 7'h00;
      pinS1 <= 7'h00;
      pinS2 <= 7'h00;
      pinS3 <= 7'h00;
    end
    else
    begin
      // RULE15 RULE13 pin drive
      gpPinOut <= next_pinOut;
      gpPinOe <= next_pinOe;
      gpPull <= next_pull;
      pinS1 <= gpPinIn;
      pinS2 <= pinS1;
      pinS3 <= pinS2;
    end
  end

  // pin values back to mclk: three more stages, then agreement
  logic [6:0] rbA;
  logic [6:0] rbB;
  logic [6:0] rbC;
  logic [6:0] next_gpRdata;
  logic [1:0] next_tin;
  logic [6:0] lModeM;
  assign lModeM = gpMode;
  // RULE19 one data bit per pin
  always_comb
  begin
    next_gpRdata = gpRdata;
    for (int i = 0; i < GP_PINS; i++)
      if (rbB[i] == rbC[i])
        next_gpRdata[i] = rbC[i];
    // RULE14 timer inputs in normal mode only (mode 0, direction 0)
    next_tin = timerInFn;
    if (!lModeM[PIN_TI0] && !gpDir[PIN_TI0])
      next_tin[0] = next_gpRdata[PIN_TI0];
    if (!lModeM[PIN_TI1] && !gpDir[PIN_TI1])
      next_tin[1] = next_gpRdata[PIN_TI1];
  end
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rbA <= 7'h00;
      rbB <= 7'h00;
      rbC <= 7'h00;
      gpRdata <= 7'h00;
      timerInFn <= 2'h0;
    end
    else
    begin
      rbA <= pinS3;
      rbB <= rbA;
      rbC <= rbB;
      gpRdata <= next_gpRdata;
      timerInFn <= next_tin;
    end
  end
endmodule // io_expansion_bus_port

// ---- verif/io_expansion_bus_port_properties.sv ----
/*
  Checker of the expansion bus pins of io_expansion_bus_port.
  Assumes the full variant and mclk at 250 MHz.
*/
`timescale 1ns/10ps
module io_expansion_bus_port_properties (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic busClockOut,
  input wire logic csN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic dataOe,
  input wire logic asyncReadyN,
  input wire logic irqCh0,
  input wire logic [3:0] irqOut,
  input wire logic sysReset,
  input wire logic sysResetN
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ==========
  // bus cycle
  sequence highFor3;
    busClockOut [*3] ##1 !busClockOut;
  endsequence
  a_bus_clk_rate: assert property ($rose(busClockOut) |-> highFor3)
    else $error("bus clock half period wrong");
  a_strobe_excl: assert property (rdN || wrN)
    else $error("strobes overlap");
  a_read_release: assert property (!rdN |-> !dataOe)
    else $error("data driven in read");
  // select may only move while the bus clock is in its high phase
  a_strobe_edge: assert property ($changed(csN) |-> busClockOut)
    else $error("select off clock edge");
  a_no_wait: assert property ($fell(csN) && asyncReadyN |-> ##[4:12] csN)
    else $error("cycle stretched");
  // ==========
  // interrupts and reset
  a_irq_sync: assert property (irqCh0 [*6] |-> irqOut[0])
    else $error("request lost");
  a_irq_idle: assert property (!irqCh0 [*6] |-> !irqOut[0])
    else $error("request while idle");
  a_reset_pair: assert property (sysReset != sysResetN)
    else $error("reset outputs disagree");
endmodule // io_expansion_bus_port_properties

bind io_expansion_bus_port io_expansion_bus_port_properties props (.mclk, .resetn,
  .busClockOut, .csN, .rdN, .wrN, .dataOe, .asyncReadyN, .irqCh0, .irqOut, .sysReset,
  .sysResetN);

// ---- verif/expansion_board_model.sv ----
/*
  One plug-in board: a 256-byte store, waitBus bus clocks of wait per cycle.
  Assumes the port's split data pins; it resolves the data wires.
*/
`timescale 1ns/10ps
module expansion_board_model (
  input wire logic busClockOut,
  input wire logic [7:0] addrOut,
  input wire logic [7:0] dataOut,
  input wire logic dataOe,
  input wire logic csN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic [3:0] waitBus,
  output logic [7:0] dataIn,
  output logic asyncReadyN
);
  logic [7:0] mem [256];
  logic [7:0] lastVal = 8'h00;
  logic drive;
  // ==========
  // data wires
  // released bus reads as the inverse of the last value read
  assign drive = !csN && !rdN;
  assign dataIn = dataOe ? dataOut : drive ? mem[addrOut] : ~lastVal;
  // no reserved pins used; sample mid-strobe, strobes move on the rising edge
  always @(negedge busClockOut)
  begin
    if (drive)
      lastVal <= mem[addrOut];
    if (!csN && !wrN)
      mem[addrOut] <= dataOut;
  end
  // ==========
  // wait states
  // stretch cycle
  initial asyncReadyN = 1'b1;
  always @(negedge csN)
  begin
    if (waitBus != 4'h0)
    begin
      #3 asyncReadyN = 1'b0;
      repeat (waitBus) @(posedge busClockOut);
      #7 asyncReadyN = 1'b1;
    end
  end
endmodule // expansion_board_model

// ---- verif/test_io_expansion_bus_port.sv ----
/*
  Directed bench of io_expansion_bus_port, full variant, one board model.
  Assumes the checker binds itself from its own file.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module test_io_expansion_bus_port;
  logic mclk = 1'b0, resetn = 1'b0, busClock = 1'b0, ioReq = 1'b0, ioWrite = 1'b0;
  logic irqCh0 = 1'b0, irqCh1 = 1'b0, irqCh3Ext = 1'b0, hitVal;
  logic [15:0] ioAddr = 16'h0000;
  logic [7:0] ioWdata = 8'h00, rdVal;
  logic [6:0] gpMode = 7'h00, gpDir = 7'h7F, gpWdata = 7'h55, extPins = 7'h2A;
  logic [1:0] timerOutFn = 2'b10;
  logic [3:0] waitBus = 4'h0;
  logic ioDone, ioHit, busClockOut, dataOe, csN, rdN, wrN, asyncReadyN, sysReset, sysResetN;
  logic [7:0] ioRdata, addrOut, dataOut, dataIn;
  logic [6:0] gpRdata, gpPinOut, gpPinOe, gpPull, gpPinIn;
  logic [3:0] irqOut;
  logic [1:0] timerInFn;
  int errors = 0, checks = 0, cyc, fastCyc;
  // a driven pin overrides the outside level
  assign gpPinIn = (gpPinOe & gpPinOut) | (~gpPinOe & extPins);
  io_expansion_bus_port #(.FULL_VARIANT(1'b1)) DUT (.mclk, .resetn, .busClock, .ioReq,
    .ioWrite, .ioAddr, .ioWdata, .ioDone, .ioHit, .ioRdata, .busClockOut, .addrOut, .dataOut,
    .dataOe, .dataIn, .csN, .rdN, .wrN, .asyncReadyN, .irqCh0, .irqCh1, .irqCh3Ext, .irqOut,
    .sysReset, .sysResetN, .gpMode, .gpDir, .gpWdata, .gpRdata, .timerOutFn, .timerInFn,
    .gpPinOut, .gpPinOe, .gpPull, .gpPinIn);
  expansion_board_model board (.busClockOut, .addrOut, .dataOut, .dataOe, .csN, .rdN, .wrN,
    .waitBus, .dataIn, .asyncReadyN);
  // ==========
  // clocks
  initial
  begin
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    #31;
    forever
    begin
      busClock = ~busClock;
      #62.5;
    end
  end
  // ==========
  // helpers
  task automatic access(input logic wr, input logic [15:0] addr, input logic [7:0] wd);
    @(posedge mclk);
    #1;
    ioWrite = wr;
    ioAddr = addr;
    ioWdata = wd;
    ioReq = 1'b1;
    cyc = 0;
    while (ioDone !== 1'b1 && cyc < 400)
    begin
      @(posedge mclk);
      #1;
      cyc++;
    end
    ioReq = 1'b0;
    @(posedge mclk);
    #1;
    rdVal = ioRdata;
    hitVal = ioHit;
    `CHK(cyc < 400, 1'b1)
  endtask
  // config crosses into the link domain slowly, so settle for 8 link periods
  // the shared serial clock is not in this set and is never reconfigured
  task automatic pins(input logic [6:0] m, input logic [6:0] d);
    gpMode = m;
    gpDir = d;
    repeat (250) @(posedge mclk);
    #1;
  endtask
  // ==========
  // scenarios
  task automatic t_bus_rw();
    access(1'b1, 16'h0000, 8'h5A);
    `CHK(hitVal, 1'b1)
    access(1'b1, 16'h00FF, 8'hA5);
    `CHK(board.mem[255], 8'hA5)
    access(1'b0, 16'h0000, 8'h00);
    `CHK(rdVal, 8'h5A)
    access(1'b0, 16'h00FF, 8'h00);
    `CHK(rdVal, 8'hA5)
    fastCyc = cyc;
    access(1'b0, 16'h0100, 8'h00);
    `CHK({hitVal, rdVal, cyc <= 2}, 10'h001)
  endtask
  task automatic t_wait();
    waitBus = 4'h3;
    access(1'b1, 16'h0042, 8'h3C);
    access(1'b0, 16'h0042, 8'h00);
    `CHK({rdVal, cyc >= fastCyc + 9}, 9'h079)
    waitBus = 4'h0;
  endtask
  task automatic t_irq();
    for (int i = 0; i < 3; i++)
    begin
      {irqCh3Ext, irqCh1, irqCh0} = 3'b001 << i;
      repeat (8) @(posedge mclk);
      #1;
      `CHK(irqOut, (i == 2) ? 4'h8 : 4'h1 << i)
      {irqCh3Ext, irqCh1, irqCh0} = 3'b000;
      repeat (8) @(posedge mclk);
      #1;
      `CHK(irqOut, 4'h0)
    end
  endtask
  task automatic t_pins();
    pins(7'h7F, 7'h00);
    `CHK({gpPinOe, gpPinOut, gpPull, gpRdata}, {7'h7F, 7'h55, 7'h00, 7'h55})
    pins(7'h00, 7'h7F);
    `CHK({gpPinOe, gpPull, gpRdata}, {7'h00, 7'h7F, 7'h2A})
    pins(7'h7F, 7'h0F);
    `CHK({gpPinOe, gpPull, gpRdata}, {7'h70, 7'h00, 7'h5A})
    pins(7'h00, 7'h00);
    `CHK({gpPinOe[1:0], gpPinOut[1:0], timerInFn}, 6'h3A)
  endtask
  // ==========
  // sequence and verdict
  initial
  begin
    repeat (16) @(posedge mclk);
    #1;
    resetn = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    `CHK({sysReset, sysResetN, csN, rdN, wrN, dataOe, irqOut}, 10'h1E0)
    t_bus_rw();
    t_wait();
    t_irq();
    t_pins();
    end_of_test();
  end
  // the run needs about 5 us; allow sixteen times that
  initial
  begin
    #80000;
    errors++;
    end_of_test();
  end
  task automatic end_of_test();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
endmodule // test_io_expansion_bus_port
